/* File: adc_analog_source.sv */
// analog side of the converter: shared pin levels, reference nodes and comparator
// assumes muxRoute and sarCode come from flops clocked by clk_sys
`timescale 1ns/10ps

module adc_analog_source (
   input  wire logic                    clk_sys,
   input  wire adc_ctl_pkg::chanRoute_t muxRoute,
   input  wire logic [7:0]              sarCode,
   input  wire logic [7:0]              pinLevel [15],
   output      logic                    compHigh
);
   import adc_ctl_pkg::*;

   logic [7:0] level;
   logic       routed;
   logic       noiseQ = 1'b0;

   // an unrouted comparator is not quiet: it flips every cycle
   always_ff @(posedge clk_sys) begin
      noiseQ <= ~noiseQ;
   end

   always_comb begin
      level  = 8'h00;
      routed = 1'b0;
      for (int i = 0; i < 15; i++) begin
         if (muxRoute.pinSel[i]) begin
            level  = pinLevel[i];
            routed = 1'b1;
         end
      end
      if (muxRoute.refHigh) begin
         level  = 8'hFF;
         routed = 1'b1;
      end
      if (muxRoute.refLow) begin
         level  = 8'h00;
         routed = 1'b1;
      end
   end

   // unused codes and power-off give no defined answer
   assign compHigh = routed ? (level >= sarCode) : noiseQ;
endmodule

/* File: adc_channel_clock_control.sv */
// converter control: register port, channel routing, conversion sequencer and
// successive approximation register
// assumes compHigh and oscClk are synchronous to clk_sys and that register
// strobes are single-cycle and never high together
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"

module adc_channel_clock_control #(
   parameter int CONV_CLOCKS = `CONV_CLOCKS
) (
   input  wire logic                    clk_sys,
   input  wire logic                    sys_rst,
   input  wire adc_ctl_pkg::regReq_t    regReq,
   output      logic [7:0]              rdData,
   input  wire logic                    oscClk,
   input  wire logic                    compHigh,
   output      adc_ctl_pkg::chanRoute_t muxRoute,
   output      logic                    sampleHold,
   output      logic [`RESULT_W-1:0]    sarCode,
   output      logic                    busy
);
   import adc_ctl_pkg::*;

   localparam int               CYC_W     = $clog2(CONV_CLOCKS);
   localparam logic [CYC_W-1:0] LAST_CYC  = CYC_W'(CONV_CLOCKS - 1);
   localparam logic [CYC_W-1:0] SAR_FIRST = CYC_W'(CONV_CLOCKS - `RESULT_W);
   localparam logic [CYC_W-1:0] SEED_CYC  = CYC_W'(CONV_CLOCKS - `RESULT_W - 1);

   // a sampling phase must precede the result bits and the bit index is 3 bits wide
   if (CONV_CLOCKS < `RESULT_W + 2 || CONV_CLOCKS > 64) begin : g_badClocks
      $error("CONV_CLOCKS out of the range the sequencer can serve");
   end

   convState_t           state_q;
   convState_t           state_d;
   logic [CYC_W-1:0]     cyc_q;
   logic [CYC_W-1:0]     cyc_d;
   logic [`CHAN_MSB:0]   chan_q;
   logic                 cont_q;
   logic                 irqEn_q;
   logic [2:0]           divCode_q;
   logic                 srcBus_q;
   logic [`RESULT_W-1:0] result_q;
   logic [`RESULT_W-1:0] trial_q;
   logic                 done_q;
   logic [7:0]           rdData_q;
   chanRoute_t           route;
   chanRoute_t           route_q;
   logic                 convTick;

   function automatic logic [`RESULT_W-1:0] sarStep(
      input logic [`RESULT_W-1:0] trial,
      input logic [2:0]           idx,
      input logic                 keep
   );
      logic [`RESULT_W-1:0] t;
      t      = trial;
      t[idx] = keep;
      if (idx != 3'h0) begin
         t[idx - 3'h1] = 1'b1;
      end
      return t;
   endfunction

   // register port decode
   wire wrStatus = regReq.wr && (regReq.addr == `OFS_STATUS_CTL);
   wire wrClock  = regReq.wr && (regReq.addr == `OFS_CLOCK_SEL);
   wire rdResult = regReq.rd && (regReq.addr == `OFS_RESULT);
   wire newOff   = (regReq.wrData[`CHAN_MSB:0] == `CHAN_OFF);

   // sequencer events; a status write in the same cycle aborts the conversion
   wire inConv   = (state_q == ST_CONVERT);
   wire lastEdge = inConv && convTick && (cyc_q == LAST_CYC);
   wire complete = lastEdge && !wrStatus;
   wire seedEdge = inConv && convTick && (cyc_q == SEED_CYC) && !wrStatus;
   wire sarEdge  = inConv && convTick && (cyc_q >= SAR_FIRST) && !wrStatus;

   wire [2:0]           bitIdx  = 3'(LAST_CYC - cyc_q);
   wire [`RESULT_W-1:0] sarNext = sarStep(trial_q, bitIdx, compHigh);

   // done is hidden while the interrupt enable is set
   wire       doneSeen   = done_q && !irqEn_q;
   wire [7:0] statusView = {doneSeen, irqEn_q, cont_q, chan_q};
   wire [7:0] clockView  = {divCode_q, srcBus_q, 4'h0};
   wire [7:0] readMux    = (regReq.addr == `OFS_STATUS_CTL) ? statusView :
                           (regReq.addr == `OFS_RESULT)     ? result_q   :
                           (regReq.addr == `OFS_CLOCK_SEL)  ? clockView  : 8'h00;

   assign rdData     = rdData_q;
   assign muxRoute   = route_q;
   assign sarCode    = trial_q;
   assign busy       = (state_q == ST_ARMED) || inConv;
   assign sampleHold = inConv && (cyc_q < SAR_FIRST);

   adc_clock_prescaler u_prescaler (
      .clk_sys  (clk_sys),
      .sys_rst  (sys_rst),
      .oscClk   (oscClk),
      .enable   (!route_q.powerOff),
      .srcBus   (srcBus_q),
      .divCode  (divCode_q),
      .convTick (convTick)
   );

   adc_channel_decode u_decode (
      .chanCode (chan_q),
      .route    (route)
   );

   // sequencer next state
   always_comb begin
      state_d = state_q;
      cyc_d   = cyc_q;
      if (wrStatus) begin
         state_d = newOff ? ST_OFF : ST_ARMED;
         cyc_d   = '0;
      end else begin
         unique case (state_q)
            ST_OFF, ST_IDLE: begin
               state_d = state_q;
            end
            ST_ARMED: begin
               if (convTick) begin
                  state_d = ST_CONVERT;
                  cyc_d   = CYC_W'(1);
               end
            end
            ST_CONVERT: begin
               if (convTick) begin
                  cyc_d = cyc_q + CYC_W'(1);
               end
               if (lastEdge) begin
                  state_d = cont_q ? ST_ARMED : ST_IDLE;
                  cyc_d   = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_OFF;
         cyc_q   <= '0;
      end else begin
         state_q <= state_d;
         cyc_q   <= cyc_d;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         chan_q  <= `CHAN_OFF;
         cont_q  <= 1'b0;
         irqEn_q <= 1'b0;
      end else if (wrStatus) begin
         chan_q  <= regReq.wrData[`CHAN_MSB:0];
         cont_q  <= regReq.wrData[`BIT_CONT];
         irqEn_q <= regReq.wrData[`BIT_IRQ_EN];
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         divCode_q <= `RST_DIV;
         srcBus_q  <= `RST_SRC_BUS;
      end else if (wrClock) begin
         divCode_q <= regReq.wrData[`DIV_MSB:`DIV_LSB];
         srcBus_q  <= regReq.wrData[`BIT_SRC_BUS];
      end
   end

   // registered routing; the power-off code also stops the prescaler
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         route_q <= '0;
         route_q.powerOff <= 1'b1;
      end else begin
         route_q <= route;
      end
   end

   // successive approximation: seed the top bit, then decide one bit per edge
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         trial_q <= '0;
      end else if (wrStatus) begin
         trial_q <= '0;
      end else if (seedEdge) begin
         trial_q <= `SAR_SEED;
      end else if (sarEdge) begin
         trial_q <= sarNext;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         result_q <= '0;
      end else if (complete) begin
         result_q <= sarNext;
      end
   end

   // done until read; a completion beside a read keeps the flag set
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (complete && !irqEn_q) begin
         done_q <= 1'b1;
      end else if (rdResult) begin
         done_q <= 1'b0;
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdData_q <= 8'h00;
      end else begin
         rdData_q <= regReq.rd ? readMux : 8'h00;
      end
   end

   sequence s_armedEdge;
      state_q == ST_ARMED && convTick && !regReq.wr && srcBus_q && divCode_q == 3'h0;
   endsequence

   sequence s_quiet15;
      (!regReq.wr)[*8] ##1 (!regReq.wr)[*7];
   endsequence

   a_conv_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_armedEdge ##1 s_quiet15 |-> complete)
      else $error("conversion did not end on its sixteenth converter edge");

   a_conv_early: assert property (@(posedge clk_sys) disable iff (sys_rst)
      s_armedEdge |=> (!complete)[*8] ##1 (!complete)[*6])
      else $error("conversion ended before sixteen converter edges");

   a_write_rearm: assert property (@(posedge clk_sys) disable iff (sys_rst)
      wrStatus && !newOff |=> state_q == ST_ARMED && !sampleHold)
      else $error("status write did not re-arm the sequencer");

   a_result_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      complete |=> result_q == $past(sarNext) && busy == $past(cont_q))
      else $error("result register missed a completed conversion");

   a_done_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
      complete && !irqEn_q |=> done_q)
      else $error("done flag not set at end of conversion");

   a_done_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      done_q && !rdResult |=> done_q)
      else $error("done flag dropped without a result read");

   a_done_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
      regReq.rd && regReq.addr == `OFS_STATUS_CTL && irqEn_q |=> !rdData[`BIT_DONE])
      else $error("done flag visible while interrupt enable is set");

   a_single_shot: assert property (@(posedge clk_sys) disable iff (sys_rst)
      complete && !cont_q |=> state_q == ST_IDLE ##1 (state_q == ST_IDLE || $past(wrStatus)))
      else $error("single conversion mode started another conversion");

   a_cont_rearm: assert property (@(posedge clk_sys) disable iff (sys_rst)
      complete && cont_q |=> state_q == ST_ARMED)
      else $error("continuous mode did not start the next conversion");

   a_reset_chan: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |-> chan_q == `CHAN_OFF && route_q.powerOff && state_q == ST_OFF)
      else $error("converter not powered off after reset");

   a_reset_src: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |-> !srcBus_q && divCode_q == `RST_DIV)
      else $error("reset did not select the oscillator clock");

   a_pin_route: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $past(chan_q) <= `CHAN_LAST_PIN && $stable(chan_q)
      |-> route_q.pinSel[chan_q[3:0]] && $onehot(route_q.pinSel))
      else $error("pin channel code routed the wrong input");

   a_ref_nodes: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $past(chan_q) == `CHAN_REF_HIGH |-> route_q.refHigh && !route_q.refLow)
      else $error("high reference code did not connect the high node");

   a_unused_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $past(chan_q) > `CHAN_LAST_PIN && $past(chan_q) < `CHAN_REF_HIGH
      |-> route_q.noInput && route_q.pinSel == '0)
      else $error("unused or reserved code connected an input");

   a_power_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
      route_q.powerOff |-> !convTick && !inConv)
      else $error("converter ran while powered off");

endmodule

/* File: adc_channel_clock_control_tb_top.sv */
// self-checking bench for the converter control block
// assumes the analog side model and the design package are compiled first
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"

module adc_channel_clock_control_tb_top;
   import adc_ctl_pkg::*;

   localparam int CONV_CLOCKS = 16;

   logic       clk_sys;
   logic       sys_rst;
   logic       oscClk;
   logic       compHigh;
   logic       sampleHold;
   logic       busy;
   logic [2:0] oscDiv;
   logic [7:0] rdData;
   logic [7:0] sarCode;
   logic [7:0] rv;
   logic [7:0] pinLevel [15];
   logic [4:0] ch;
   regReq_t    regReq;
   chanRoute_t muxRoute;
   int         num_errors;
   int         samples_checked;
   int         n;
   int         div;
   int         hold;

   adc_channel_clock_control #(.CONV_CLOCKS(CONV_CLOCKS)) u_dut (
      .clk_sys    (clk_sys),
      .sys_rst    (sys_rst),
      .regReq     (regReq),
      .rdData     (rdData),
      .oscClk     (oscClk),
      .compHigh   (compHigh),
      .muxRoute   (muxRoute),
      .sampleHold (sampleHold),
      .sarCode    (sarCode),
      .busy       (busy)
   );

   adc_analog_source u_analog (
      .clk_sys  (clk_sys),
      .muxRoute (muxRoute),
      .sarCode  (sarCode),
      .pinLevel (pinLevel),
      .compHigh (compHigh)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // oscillator at one eighth of the system clock
   always @(posedge clk_sys) begin
      oscDiv <= oscDiv + 3'h1;
      oscClk <= oscDiv[2];
   end

   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
      end
   endtask

   task automatic regWr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regReq.addr   <= a;
      regReq.wrData <= d;
      regReq.wr     <= 1'b1;
      @(posedge clk_sys);
      regReq.wr     <= 1'b0;
   endtask

   task automatic regRd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regReq.addr <= a;
      regReq.rd   <= 1'b1;
      @(posedge clk_sys);
      regReq.rd   <= 1'b0;
      #1 d = rdData;
   endtask

   task automatic convert(output int cnt);
      cnt = 0;
      hold = 0;
      do begin
         @(posedge clk_sys);
         #1 cnt++;
         if (sampleHold === 1'b1)
            hold++;
      end while (busy !== 1'b0 && cnt < 2000);
      check(busy, 1'b0);
   endtask

   function automatic int divRatio(input logic [2:0] code);
      return code[2] ? 16 : (1 << code);
   endfunction

   function automatic logic [18:0] expRoute(input logic [4:0] c);
      logic [14:0] pins;
      pins = (c < 5'h0F) ? (15'h0001 << c) : 15'h0000;
      return {pins, c == 5'h1D, c == 5'h1E, c == 5'h1F, c > 5'h0E && c < 5'h1D};
   endfunction

   function automatic logic [7:0] expLevel(input logic [4:0] c);
      return (c < 5'h0F) ? pinLevel[c] : ((c == 5'h1D) ? 8'hFF : 8'h00);
   endfunction

   // single conversion on channel c with span limits for divide ratio r
   task automatic oneShot(input logic [4:0] c, input int r, input logic chk);
      regWr(`OFS_STATUS_CTL, {3'b000, c});
      convert(n);
      check(n >= (CONV_CLOCKS - 1) * r && n <= (CONV_CLOCKS + 1) * r + 4, 1'b1);
      // seven converter clocks of sampling before the first bit decision
      check(hold, 7 * r);
      if (chk)
         check(sarCode, expLevel(c));
      check(muxRoute, expRoute(c));
      regRd(`OFS_STATUS_CTL, rv);
      check(rv, {3'b100, c});
      regRd(`OFS_RESULT, rv);
      if (chk)
         check(rv, expLevel(c));
      regRd(`OFS_STATUS_CTL, rv);
      check(rv, {3'b000, c});
   endtask

   initial begin
      #200_000;
      num_errors++;
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      regReq  = '0;
      oscDiv  = 3'h0;
      oscClk  = 1'b0;
      num_errors = 0;
      samples_checked = 0;
      rv = 8'($urandom(83));
      foreach (pinLevel[i]) pinLevel[i] = 8'($urandom_range(255, 0));
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1 check(muxRoute, expRoute(5'h1F));
      check(busy, 1'b0);
      regRd(`OFS_STATUS_CTL, rv);
      check(rv, 8'h1F);
      regRd(`OFS_CLOCK_SEL, rv);
      check(rv, 8'h00);
      // first result after power-off is thrown away
      oneShot(5'h03, 8, 1'b0);
      oneShot(5'h03, 8, 1'b1);
      // read-only and unmapped places
      regWr(`OFS_RESULT, 8'h5A);
      regRd(`OFS_RESULT, rv);
      check(rv, expLevel(5'h03));
      regRd(2'h3, rv);
      check(rv, 8'h00);
      regWr(`OFS_CLOCK_SEL, 8'hFF);
      regRd(`OFS_CLOCK_SEL, rv);
      check(rv, 8'hF0);
      // source and divider set only while idle
      for (int code = 0; code < 8; code++) begin
         regWr(`OFS_CLOCK_SEL, {3'(code), 1'b1, 4'h0});
         ch = 5'($urandom_range(14, 0));
         pinLevel[ch] <= 8'($urandom_range(255, 0));
         div = divRatio(3'(code));
         oneShot(ch, div, 1'b1);
      end
      regWr(`OFS_CLOCK_SEL, 8'h10);
      oneShot(5'h00, 1, 1'b1);
      oneShot(5'h0E, 1, 1'b1);
      oneShot(5'h1D, 1, 1'b1);
      oneShot(5'h1E, 1, 1'b1);
      oneShot(5'h0F, 1, 1'b0);
      oneShot(5'h1A, 1, 1'b0);
      oneShot(5'h1C, 1, 1'b0);
      // enabled interrupt hides the done flag
      regWr(`OFS_STATUS_CTL, 8'h45);
      convert(n);
      regRd(`OFS_STATUS_CTL, rv);
      check(rv, 8'h45);
      regRd(`OFS_RESULT, rv);
      check(rv, expLevel(5'h05));
      // continuous mode picks up a changed level without software help
      regWr(`OFS_STATUS_CTL, 8'h27);
      repeat (40) @(posedge clk_sys);
      pinLevel[7] <= ~pinLevel[7];
      repeat (40) @(posedge clk_sys);
      #1 check(busy, 1'b1);
      regRd(`OFS_RESULT, rv);
      check(rv, expLevel(5'h07));
      oneShot(5'h07, 1, 1'b1);
      repeat (40) @(posedge clk_sys);
      #1 check(busy, 1'b0);
      // second reset in the middle of a continuous run
      regWr(`OFS_STATUS_CTL, 8'h22);
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      regRd(`OFS_STATUS_CTL, rv);
      check(rv, 8'h1F);
      regRd(`OFS_CLOCK_SEL, rv);
      check(rv, 8'h00);
      // power-off stops all conversion
      regWr(`OFS_STATUS_CTL, 8'h1F);
      repeat (40) @(posedge clk_sys);
      #1 check(busy, 1'b0);
      check(muxRoute, expRoute(5'h1F));
      summarize();
   end
endmodule

/* File: adc_channel_decode.sv */
// channel code to analog routing decoder
// assumes the caller registers the route before it reaches the analog switches
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"

module adc_channel_decode (
   input  wire logic [`CHAN_MSB:0]     chanCode,
   output      adc_ctl_pkg::chanRoute_t route
);
   import adc_ctl_pkg::*;

   function automatic chanRoute_t decodeChan(input logic [`CHAN_MSB:0] code);
      chanRoute_t r;
      r = '0;
      if (code <= `CHAN_LAST_PIN) begin
         r.pinSel[code[3:0]] = 1'b1;
      end
      r.refHigh  = (code == `CHAN_REF_HIGH);
      r.refLow   = (code == `CHAN_REF_LOW);
      r.powerOff = (code == `CHAN_OFF);
      // unused and reserved: converter still runs, nothing is connected
      r.noInput  = (code > `CHAN_LAST_PIN) && !r.refHigh && !r.refLow && !r.powerOff;
      return r;
   endfunction

   assign route = decodeChan(chanCode);

endmodule

/* File: adc_clock_prescaler.sv */
// converter clock source select and prescaler, producing one tick per converter edge
// assumes oscClk is sampled by clk_sys and runs below half its rate
`timescale 1ns/10ps
`include "adc_ctl_regs.svh"

module adc_clock_prescaler (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       oscClk,
   input  wire logic       enable,
   input  wire logic       srcBus,
   input  wire logic [2:0] divCode,
   output      logic       convTick
);
   logic       oscPrev_q;
   logic [3:0] cnt_q;

   function automatic logic [3:0] lastIndex(input logic [2:0] code);
      if (code[2]) begin
         return `DIV_TOP_LAST;
      end
      return 4'((5'h01 << code[1:0]) - 5'h01);
   endfunction

   wire       srcTick = srcBus ? 1'b1 : (oscClk && !oscPrev_q);
   wire [3:0] lastIdx = lastIndex(divCode);
   wire       wrapNow = (cnt_q >= lastIdx);

   assign convTick = enable && srcTick && wrapNow;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         oscPrev_q <= 1'b0;
         cnt_q     <= 4'h0;
      end else begin
         oscPrev_q <= oscClk;
         // a powered-off converter clears the divider so its clock stands still
         if (!enable) begin
            cnt_q <= 4'h0;
         end else if (srcTick) begin
            cnt_q <= wrapNow ? 4'h0 : cnt_q + 4'h1;
         end
      end
   end

   a_bus_div_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
      enable && srcBus && divCode == 3'h0 |-> convTick)
      else $error("bus clock divided by one missed a converter edge");

   a_osc_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !srcBus && !(oscClk && !$past(oscClk)) |-> !convTick)
      else $error("converter edge without an oscillator rising edge");

endmodule

/* File: adc_ctl_pkg.sv */
// types shared by the converter control block
// assumes the constants header is on the include path
`include "adc_ctl_regs.svh"

package adc_ctl_pkg;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_IDLE,
      ST_ARMED,
      ST_CONVERT
   } convState_t;

   typedef struct packed {
      logic [`PIN_COUNT-1:0] pinSel;
      logic                  refHigh;
      logic                  refLow;
      logic                  powerOff;
      logic                  noInput;
   } chanRoute_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wrData;
      logic       wr;
      logic       rd;
   } regReq_t;

endpackage

/* File: adc_ctl_regs.svh */
// register offsets, field positions, reset values and counts of the converter control
// assumes an 8-bit register port addressed by a two-bit word index
// Function
// - channel codes 00h-07h and 08h-0Eh route shared port pins to the converter
// - codes 0Fh-1Ah and 1Ch are unused, 1Bh reserved; results are unknown
// - code 1Dh selects the high reference, code 1Eh the low reference
// - channel code 1Fh powers the whole converter off
// - reset loads all ones into the channel field, so the converter starts off
// - one 8-bit result register, loaded at every completed conversion
// - divide field divides input clock by 1, 2, 4, 8, or 16 when top bit set
// - source bit one picks the bus clock, zero picks the oscillator clock
// - reset selects the oscillator clock as converter clock source
// - conversion takes sixteen converter clocks, starting on first edge after write
// - with interrupts disabled, done flag sets at end, holds until result read
// - continuous bit converts repeatedly; clear bit gives exactly one conversion
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

`define OFS_STATUS_CTL 2'h0
`define OFS_RESULT     2'h1
`define OFS_CLOCK_SEL  2'h2

`define BIT_DONE       7
`define BIT_IRQ_EN     6
`define BIT_CONT       5
`define CHAN_MSB       4
`define DIV_MSB        7
`define DIV_LSB        5
`define BIT_SRC_BUS    4

`define CHAN_OFF       5'h1F
`define CHAN_LAST_PIN  5'h0E
`define CHAN_RESERVED  5'h1B
`define CHAN_REF_HIGH  5'h1D
`define CHAN_REF_LOW   5'h1E
`define PIN_COUNT      15

`define RST_DIV        3'h0
`define RST_SRC_BUS    1'b0
`define DIV_TOP_LAST   4'hF
`define SAR_SEED       8'h80

`define RESULT_W       8
`define CONV_CLOCKS    16

`endif
